// File: logic/ecp_parallel_link.sv
`include "ecp_link_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module ecp_parallel_link (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Control
  input wire logic [2:0] mode_i,
  input wire logic direction_i,
  // System forward stream
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_cmd_i,
  output logic wr_ready_o,
  // System reverse stream
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  output logic rd_cmd_o,
  input wire logic rd_ready_i,
  // Status to system
  output logic dma_req_o,
  output logic error_irq_o,
  output logic reverse_hint_o,
  // Link pins
  output logic nstrobe_o,
  output logic host_ack_n_o,
  output logic reverse_req_n_o,
  output logic nselectin_o,
  input wire logic [7:0] pdata_i,
  output logic [7:0] pdata_o,
  output logic pdata_oe_o,
  input wire logic periph_ack_i,
  input wire logic periph_clk_n_i,
  input wire logic ack_reverse_n_i,
  input wire logic periph_request_n_i
);

  // Two-stage synchronisers for every pin input
  logic [11:0] sync1_reg;
  logic [11:0] sync2_reg;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // Pins idle: request, reverse ack and data valid high, busy low
      sync1_reg <= 12'he00;
      sync2_reg <= 12'he00;
    end else begin
      sync1_reg <= {periph_request_n_i, ack_reverse_n_i, periph_clk_n_i, periph_ack_i, pdata_i};
      sync2_reg <= sync1_reg;
    end
  end
  logic fault_n_s; // Peripheral request / fault, active low
  logic ack_rev_n_s; // Reverse acknowledge, high means forward
  logic pclk_n_s; // Peripheral data valid, active low
  logic busy_s; // Peripheral busy / command tag
  logic [7:0] pdata_s;
  assign {fault_n_s, ack_rev_n_s, pclk_n_s, busy_s, pdata_s} = sync2_reg;

  // Mode decode
  logic ecp_mode; // Full ECP protocol
  logic compat_mode; // Printer FIFO, forward only
  logic active;
  logic dir_rev; // Effective reverse direction
  assign ecp_mode = (mode_i == `MODE_ECP);
  assign compat_mode = (mode_i == `MODE_COMPAT_FIFO);
  assign active = ecp_mode | compat_mode;
  assign dir_rev = ecp_mode & direction_i;

  // Shared FIFO storage; word is {cmd tag, byte}
  logic [`WORD_W-1:0] fifo_mem [`FIFO_DEPTH];
  logic [`FIFO_PTR_W-1:0] wr_ptr_reg;
  logic [`FIFO_PTR_W-1:0] rd_ptr_reg;
  logic [`FIFO_CNT_W-1:0] count_reg;
  logic [`FIFO_CNT_W-1:0] count_next;
  logic full;
  logic empty;
  assign full = (count_reg == `FIFO_FULL_CNT);
  assign empty = (count_reg == 5'h00);

  ecp_link_pkg::link_state_type state_reg;
  logic host_ack_n_reg;
  logic [6:0] rle_cnt_reg; // Held repeat count
  logic rle_pend_reg; // A count byte is waiting for its data byte
  logic [6:0] rep_reg; // Copies still to push, less one
  logic [7:0] rle_byte_reg;

  // Reverse byte classification: busy low means command
  logic rev_cmd;
  logic rev_rle;
  logic capture;
  assign rev_cmd = ~busy_s;
  assign rev_rle = rev_cmd & ~pdata_s[7];
  assign capture = (state_reg == ecp_link_pkg::REV_WAIT) & ~host_ack_n_reg & ~pclk_n_s;

  // FIFO push and pop sources; the handshakes only run when space or data exists
  logic push;
  logic pop;
  logic [`WORD_W-1:0] push_word;
  logic link_pop;
  logic sys_pop;
  logic link_push;
  assign link_push = (capture & ~rev_rle & ~(rle_pend_reg & ~rev_cmd))
                   | ((state_reg == ecp_link_pkg::REV_RLE) & ~full);
  assign link_pop = (state_reg == ecp_link_pkg::LINK_IDLE) & active & ~dir_rev & ~empty
                  & (ack_rev_n_s | compat_mode);
  assign sys_pop = dir_rev & ~empty & (~rd_valid_o | rd_ready_i);
  assign push = link_push | (~dir_rev & wr_valid_i & wr_ready_o);
  assign pop = link_pop | sys_pop;
  assign push_word = (state_reg == ecp_link_pkg::REV_RLE) ? {1'b0, rle_byte_reg}
                   : capture ? {rev_cmd, pdata_s} : {wr_cmd_i, wr_data_i};
  assign count_next = count_reg + {4'h0, push} - {4'h0, pop};

  // Storage write; no reset needed on the array itself
  always_ff @(posedge clk_i) begin
    if (push) begin
      fifo_mem[wr_ptr_reg] <= push_word;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      count_reg <= 5'h00;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 4'h1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 4'h1;
      end
      count_reg <= count_next;
    end
  end

  // System side: ready, reverse output stage and DMA request
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ready_o <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o <= 8'h00;
      rd_cmd_o <= 1'b0;
      dma_req_o <= 1'b0;
    end else begin
      // Registered from the next count so the FIFO never overflows
      wr_ready_o <= active & ~dir_rev & (count_next != `FIFO_FULL_CNT);
      if (sys_pop) begin
        rd_valid_o <= 1'b1;
        {rd_cmd_o, rd_data_o} <= fifo_mem[rd_ptr_reg];
      end else if (rd_ready_i) begin
        rd_valid_o <= 1'b0;
      end
      // Burst DMA request in either direction
      dma_req_o <= active & (dir_rev ? (count_next != 5'h00)
                                     : (count_next != `FIFO_FULL_CNT));
    end
  end

  // Fault pin: error interrupt and reverse hint, software decides direction
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      error_irq_o <= 1'b0;
      reverse_hint_o <= 1'b0;
    end else begin
      error_irq_o <= ~fault_n_s;
      reverse_hint_o <= ecp_mode & ~dir_rev & ~fault_n_s;
    end
  end

  // Select-in deasserted throughout ECP mode
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nselectin_o <= 1'b1;
    end else begin
      nselectin_o <= ecp_mode | ~active;
    end
  end

  // Link handshake engine; no negotiation phase, software sets the mode
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ecp_link_pkg::LINK_IDLE;
      nstrobe_o <= 1'b1;
      host_ack_n_reg <= 1'b1;
      reverse_req_n_o <= 1'b1;
      pdata_o <= 8'h00;
      pdata_oe_o <= 1'b0;
      rle_cnt_reg <= 7'h00;
      rle_pend_reg <= 1'b0;
      rep_reg <= 7'h00;
      rle_byte_reg <= 8'h00;
    end else begin
      case (state_reg)
        ecp_link_pkg::LINK_IDLE: begin
          nstrobe_o <= 1'b1;
          // Bus released unless forward is acknowledged; compat mode drives it without the acknowledge
          pdata_oe_o <= active & ~dir_rev & (ack_rev_n_s | compat_mode);
          if (link_pop) begin
            // Byte and tag set up one cycle ahead of the strobe
            pdata_o <= fifo_mem[rd_ptr_reg][7:0];
            if (compat_mode) begin
              host_ack_n_reg <= 1'b1;
            end else begin
              host_ack_n_reg <= ~fifo_mem[rd_ptr_reg][8];
            end
            state_reg <= ecp_link_pkg::FWD_SETUP;
          end else if (dir_rev) begin
            pdata_oe_o <= 1'b0;
            reverse_req_n_o <= 1'b0;
            host_ack_n_reg <= 1'b1;
            state_reg <= ecp_link_pkg::REV_REQ;
          end
        end
        ecp_link_pkg::FWD_SETUP: begin
          // Peripheral ready when busy low
          if (!busy_s) begin
            nstrobe_o <= 1'b0;
            state_reg <= ecp_link_pkg::FWD_STROBE;
          end
        end
        ecp_link_pkg::FWD_STROBE: begin
          if (busy_s) begin
            nstrobe_o <= 1'b1;
            state_reg <= ecp_link_pkg::FWD_RELEASE;
          end
        end
        ecp_link_pkg::FWD_RELEASE: begin
          // Wait for busy to drop before the next byte
          if (!busy_s) begin
            state_reg <= ecp_link_pkg::LINK_IDLE;
          end
        end
        ecp_link_pkg::REV_REQ: begin
          if (!ack_rev_n_s) begin
            state_reg <= ecp_link_pkg::REV_WAIT;
          end
        end
        ecp_link_pkg::REV_WAIT: begin
          if (!dir_rev && (host_ack_n_reg || pclk_n_s)) begin
            // Leave when no byte is presented, even with a request pending;
            // a byte started inside the pin latency can still be lost
            reverse_req_n_o <= 1'b1;
            host_ack_n_reg <= 1'b1;
            state_reg <= ecp_link_pkg::REV_EXIT;
          end else if (host_ack_n_reg) begin
            // Request a byte only while there is room
            host_ack_n_reg <= full;
          end else if (capture) begin
            host_ack_n_reg <= 1'b1;
            state_reg <= ecp_link_pkg::REV_ACK;
            if (rev_rle) begin
              rle_cnt_reg <= pdata_s[6:0];
              rle_pend_reg <= 1'b1;
            end else if (rle_pend_reg && !rev_cmd) begin
              // Count n gives n plus one copies
              rle_pend_reg <= 1'b0;
              rle_byte_reg <= pdata_s;
              rep_reg <= rle_cnt_reg;
              state_reg <= ecp_link_pkg::REV_RLE;
            end
          end
        end
        ecp_link_pkg::REV_RLE: begin
          // No next byte requested until all copies are stored; host ack already went high at capture
          if (!full) begin
            rep_reg <= rep_reg - 7'h01;
            if (rep_reg == 7'h00) begin
              state_reg <= ecp_link_pkg::REV_ACK;
            end
          end
        end
        ecp_link_pkg::REV_ACK: begin
          if (pclk_n_s) begin
            state_reg <= ecp_link_pkg::REV_WAIT;
          end
        end
        ecp_link_pkg::REV_EXIT: begin
          if (ack_rev_n_s) begin
            state_reg <= ecp_link_pkg::LINK_IDLE;
          end
        end
        default: begin
          state_reg <= ecp_link_pkg::LINK_IDLE;
        end
      endcase
    end
  end
  assign host_ack_n_o = host_ack_n_reg;

  // Checks
  property p_fifo_bound;
    @(posedge clk_i) disable iff (!resetn_i) count_reg <= `FIFO_FULL_CNT;
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("FIFO count above depth");
  property p_selin;
    @(posedge clk_i) disable iff (!resetn_i) $past(ecp_mode) |-> nselectin_o;
  endproperty
  a_selin: assert property (p_selin) else $error("Select-in asserted in ECP mode");
  property p_oe;
    @(posedge clk_i) disable iff (!resetn_i)
      (pdata_oe_o && $past(ecp_mode)) |-> ($past(ack_rev_n_s) && reverse_req_n_o);
  endproperty
  a_oe: assert property (p_oe) else $error("Data bus driven in reverse");
  property p_irq;
    @(posedge clk_i) disable iff (!resetn_i) $fell(fault_n_s) |=> error_irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("Fault did not raise interrupt");
  property p_strobe;
    @(posedge clk_i) disable iff (!resetn_i) $fell(nstrobe_o) |-> !$past(busy_s);
  endproperty
  a_strobe: assert property (p_strobe) else $error("Strobe while peripheral busy");
  property p_empty;
    @(posedge clk_i) disable iff (!resetn_i)
      (state_reg == ecp_link_pkg::LINK_IDLE && empty) |=> nstrobe_o [*2];
  endproperty
  a_empty: assert property (p_empty) else $error("Strobe with empty FIFO");
  property p_rev_init;
    @(posedge clk_i) disable iff (!resetn_i)
      (state_reg == ecp_link_pkg::REV_WAIT) |-> !reverse_req_n_o;
  endproperty
  a_rev_init: assert property (p_rev_init) else $error("Reverse without init low");
  property p_tag;
    @(posedge clk_i) disable iff (!resetn_i)
      (state_reg == ecp_link_pkg::FWD_STROBE && ecp_mode)
      |-> ($stable(host_ack_n_o) && $stable(pdata_o));
  endproperty
  a_tag: assert property (p_tag) else $error("Tag changed during strobe");
  property p_rev_full;
    @(posedge clk_i) disable iff (!resetn_i)
      (state_reg == ecp_link_pkg::REV_WAIT && host_ack_n_reg && full) |=> host_ack_n_o;
  endproperty
  a_rev_full: assert property (p_rev_full) else $error("Byte requested with FIFO full");
  c_fwd: cover property (@(posedge clk_i) disable iff (!resetn_i)
    state_reg == ecp_link_pkg::FWD_STROBE ##[1:50] state_reg == ecp_link_pkg::LINK_IDLE);
  c_rev: cover property (@(posedge clk_i) disable iff (!resetn_i) capture && !rev_rle);
  c_rle: cover property (@(posedge clk_i) disable iff (!resetn_i)
    state_reg == ecp_link_pkg::REV_RLE ##1 state_reg == ecp_link_pkg::REV_ACK);

endmodule // ecp_parallel_link
`default_nettype wire

// File: include/ecp_link_defs.svh
`ifndef ECP_LINK_DEFS_SVH
`define ECP_LINK_DEFS_SVH
// Mode field codes
`define MODE_COMPAT_FIFO 3'h2
`define MODE_ECP 3'h3
// Shared byte FIFO depth and pointer width
`define FIFO_DEPTH 16
`define FIFO_PTR_W 4
`define FIFO_CNT_W 5
// Full level at count width
`define FIFO_FULL_CNT 5'h10
// Width of a FIFO word: command tag plus byte
`define WORD_W 9
`endif

// File: include/ecp_link_pkg.sv
package ecp_link_pkg;
  // Link handshake states
  typedef enum logic [3:0] {
    LINK_IDLE,
    FWD_SETUP,
    FWD_STROBE,
    FWD_RELEASE,
    REV_REQ,
    REV_WAIT,
    REV_RLE,
    REV_ACK,
    REV_EXIT
  } link_state_type;
endpackage

// File: tb/ecp_periph_model.sv
`timescale 1ns/10ps
`default_nettype none
module ecp_periph_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Host pins and wire level
  input wire logic nstrobe_i,
  input wire logic host_ack_n_i,
  input wire logic reverse_req_n_i,
  input wire logic [7:0] bus_i,
  // Slow answers when high
  input wire logic slow_i,
  // Peripheral pins
  output logic busy_o,
  output logic nack_o,
  output logic ack_reverse_n_o,
  output logic [7:0] pdata_o
);
  logic [8:0] fwd_q[$]; // Captured words: host ack level, then byte
  logic [8:0] rev_q[$]; // Words to send: command flag, then byte
  logic [8:0] word;
  // One or twelve cycles, so the host sees both fast and slow answers
  task automatic pause();
    repeat (slow_i ? 12 : 1) @(posedge clk_i);
  endtask
  // One process owns every pin, so no pin has two drivers
  initial begin
    busy_o = 1'b0;
    nack_o = 1'b1;
    ack_reverse_n_o = 1'b1;
    pdata_o = 8'h5a;
    forever begin
      @(posedge clk_i);
      if (resetn_i && !nstrobe_i && !busy_o && ack_reverse_n_o) begin
        // Forward: take the byte on the strobe, busy interlocks with it
        fwd_q.push_back({host_ack_n_i, bus_i});
        pause();
        busy_o <= 1'b1;
        do @(posedge clk_i); while (!nstrobe_i);
        pause();
        busy_o <= 1'b0;
      end else if (resetn_i && !reverse_req_n_i && ack_reverse_n_o) begin
        // Turn the link round on the host's request
        pause();
        ack_reverse_n_o <= 1'b0;
      end else if (reverse_req_n_i && !ack_reverse_n_o) begin
        pause();
        ack_reverse_n_o <= 1'b1;
        busy_o <= 1'b0;
      end else if (!ack_reverse_n_o && !host_ack_n_i && rev_q.size() > 0) begin
        // Reverse: one byte per host request
        word = rev_q.pop_front();
        pdata_o <= word[7:0];
        busy_o <= ~word[8];
        pause();
        nack_o <= 1'b0;
        do @(posedge clk_i); while (!host_ack_n_i);
        // Released bus shows the inverse, so a stale capture is caught
        pdata_o <= ~word[7:0];
        pause();
        nack_o <= 1'b1;
      end
    end
  end
endmodule // ecp_periph_model
`default_nettype wire

// File: tb/ecp_parallel_link_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ecp_parallel_link_tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [2:0] mode = 3'h3;
  logic dir = 1'b0, wv = 1'b0, wc = 1'b0, rr = 1'b0, flt_n = 1'b1, slow = 1'b0;
  logic [7:0] wd = 8'h00;
  wire logic [7:0] pd, pp, bus, rd;
  wire logic wrdy, rv, rc, irq, hint, oe, nstb, hak_n, rreq_n, nsel, busy, nack, akr_n, dma;
  int n_errors = 0, total_checks = 0, cyc = 0;
  // Host wins the wire while its enable is up
  assign bus = oe ? pd : pp;
  initial forever #5 clk_i = ~clk_i;
  ecp_parallel_link dut (.clk_i(clk_i), .resetn_i(resetn_i), .mode_i(mode),
    .direction_i(dir), .wr_valid_i(wv), .wr_data_i(wd), .wr_cmd_i(wc), .wr_ready_o(wrdy),
    .rd_valid_o(rv), .rd_data_o(rd), .rd_cmd_o(rc), .rd_ready_i(rr), .dma_req_o(dma),
    .error_irq_o(irq), .reverse_hint_o(hint), .nstrobe_o(nstb), .host_ack_n_o(hak_n),
    .reverse_req_n_o(rreq_n), .nselectin_o(nsel), .pdata_i(bus), .pdata_o(pd),
    .pdata_oe_o(oe), .periph_ack_i(busy), .periph_clk_n_i(nack),
    .ack_reverse_n_i(akr_n), .periph_request_n_i(flt_n));
  ecp_periph_model periph (.clk_i(clk_i), .resetn_i(resetn_i), .nstrobe_i(nstb),
    .host_ack_n_i(hak_n), .reverse_req_n_i(rreq_n), .bus_i(bus), .slow_i(slow),
    .busy_o(busy), .nack_o(nack), .ack_reverse_n_o(akr_n), .pdata_o(pp));
  task automatic complete_run();
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Hold the word until the edge where ready is seen high
  task automatic send(input logic c, input logic [7:0] d, output int w);
    w = 0;
    wv <= 1'b1;
    wc <= c;
    wd <= d;
    do begin @(posedge clk_i); w++; end while (!wrdy && w < 3000);
  endtask
  // Caller keeps rr high, so back-to-back takes are legal
  task automatic take(input logic [8:0] exp);
    int w = 0;
    do begin @(posedge clk_i); w++; end while (!(rv && rr) && w < 3000);
    chk({rc, rd}, exp);
  endtask
  task automatic wait_fwd(input int n);
    for (int i = 0; i < 3000 && periph.fwd_q.size() < n; i++) @(posedge clk_i);
    // Let the last strobe and busy exchange close before looking at the pins
    repeat (40) @(posedge clk_i);
  endtask
  task automatic t_forward();
    int w;
    send(1'b0, 8'h41, w);
    send(1'b1, 8'h92, w);
    send(1'b0, 8'hff, w);
    wv <= 1'b0;
    wait_fwd(3);
    chk(periph.fwd_q.pop_front(), 9'h141);
    chk(periph.fwd_q.pop_front(), 9'h092);
    chk(periph.fwd_q.pop_front(), 9'h1ff);
    chk({6'h00, dma, nstb, nsel}, 9'h007);
  endtask
  // Slow peripheral, so the queue fills and refuses
  task automatic t_fill();
    int w, at;
    at = -1;
    slow <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      send(1'b0, 8'(i), w);
      if (w > 1 && at < 0) at = i;
    end
    wv <= 1'b0;
    chk({8'h00, at == 16 || at == 17}, 9'h001);
    slow <= 1'b0;
    wait_fwd(20);
    for (int i = 0; i < 20; i++) chk(periph.fwd_q.pop_front(), {1'b1, 8'(i)});
  endtask
  task automatic t_fault();
    flt_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk({7'h00, irq, hint}, 9'h003);
    flt_n <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk({8'h00, irq}, 9'h000);
  endtask
  task automatic t_reverse();
    int n;
    dir <= 1'b1;
    rr <= 1'b1;
    periph.rev_q = '{9'h185, 9'h033, 9'h103, 9'h0a5, 9'h0c3};
    take(9'h185);
    take(9'h033);
    repeat (4) take(9'h0a5);
    take(9'h0c3);
    chk({7'h00, rreq_n, oe}, 9'h000);
    // Consumer stalls: the host must stop asking, losing nothing
    rr <= 1'b0;
    for (int i = 0; i < 20; i++) periph.rev_q.push_back({1'b0, 8'h20 + 8'(i)});
    repeat (600) @(posedge clk_i);
    n = periph.rev_q.size();
    // Sixteen stored plus one in the output stage: three left unasked
    chk({dma, 8'(n)}, 9'h103);
    rr <= 1'b1;
    for (int i = 0; i < 20; i++) take({1'b0, 8'h20 + 8'(i)});
    chk({8'h00, dma}, 9'h000);
    dir <= 1'b0;
    for (int i = 0; i < 3000 && !(rreq_n && akr_n); i++) @(posedge clk_i);
    chk({8'h00, rreq_n}, 9'h001);
  endtask
  task automatic t_compat();
    int w;
    mode <= 3'h2;
    send(1'b0, 8'h77, w);
    wv <= 1'b0;
    wait_fwd(1);
    chk(periph.fwd_q.pop_front(), 9'h177);
  endtask
  // Hang guard: a run of under two thousand cycles is expected
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    chk({nstb, hak_n, rreq_n, nsel, oe, 4'h0}, 9'h1e0);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    t_forward();
    t_fill();
    t_fault();
    t_reverse();
    t_compat();
    complete_run();
  end
endmodule // ecp_parallel_link_tb
`default_nettype wire
